// file: hw/irq_map_pkg.sv
// Constants shared by the upper interrupt pin mapping logic.
package irq_map_pkg;
   localparam int REG_AW = 8;
   localparam int REG_DW = 8;
   localparam logic [7:0] PIN_ONE_MAP_ADDR = 8'h3A;
   localparam logic [7:0] PIN_TWO_MAP_ADDR = 8'h3B;
   localparam logic [7:0] STATUS_TWO_ADDR = 8'h0F;
   localparam logic [7:0] MAP_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] MAP_WRITABLE = 8'hDF;
   localparam logic [7:0] READ_IDLE = 8'h00;
   localparam int FUSE_ERROR_BIT = 7;
   localparam int USER_REG_ERROR_BIT = 6;
   localparam int RESERVED_BIT = 5;
   localparam int KEEPALIVE_BIT = 4;
   localparam int AUX_ACTIVITY_BIT = 3;
   localparam int AUX_INACTIVITY_BIT = 2;
   localparam int DOUBLE_KNOCK_BIT = 1;
   localparam int SINGLE_KNOCK_BIT = 0;
   localparam int STATUS_KEEPALIVE_BIT = 4;
endpackage

// file: hw/event_route_if.sv
// Carrier between the register side and the pin router.
interface event_route_if;
   logic [7:0] source_vec;
   logic [7:0] map_one;
   logic [7:0] map_two;
   logic lower_one;
   logic lower_two;
   logic pin_one;
   logic pin_two;
   modport ctrl (output source_vec, output map_one, output map_two, output lower_one,
                 output lower_two, input pin_one, input pin_two);
   modport router (input source_vec, input map_one, input map_two, input lower_one,
                   input lower_two, output pin_one, output pin_two);
endinterface

// file: hw/event_pin_router.sv
// Masks event sources with the pin maps and registers the two pin levels.
module event_pin_router (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic clk_en_i,
   event_route_if.router route
);
   logic [7:0] hit_one;
   logic [7:0] hit_two;
   logic next_pin_one;
   logic next_pin_two;
   logic pin_one;
   logic pin_two;

   assign hit_one = route.source_vec & route.map_one;
   assign hit_two = route.source_vec & route.map_two;
   // RULE_17: OR of sources.
   assign next_pin_one = (|hit_one) | route.lower_one;
   assign next_pin_two = (|hit_two) | route.lower_two;

   // Registering the pins keeps glitches of the source decode off the board.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_one <= 1'b0;
         pin_two <= 1'b0;
      end else if (clk_en_i) begin
         pin_one <= next_pin_one;
         pin_two <= next_pin_two;
      end
   end

   assign route.pin_one = pin_one;
   assign route.pin_two = pin_two;
endmodule // event_pin_router

// file: hw/upper_irq_map.sv
// Upper interrupt pin mapping registers, keep-alive status and pin drive.

// Overview of operation
// RULE_01: Pin one map at 0x3A, resets 0x00.
// RULE_02: Pin two map at 0x3B, resets 0x00.
// RULE_03: Bit 7 routes fuse error to pin one.
// RULE_04: Bit 7 routes fuse error to pin two.
// RULE_05: Bit 6 routes register error to pin one.
// RULE_06: Bit 6 routes register error to pin two.
// RULE_07: Bit 4 routes keep-alive expiry to its pin.
// RULE_08: Bit 3 routes aux activity to pin one.
// RULE_09: Bit 3 routes aux activity to pin two.
// RULE_10: Bit 2 routes aux inactivity to pin one.
// RULE_11: Bit 2 routes aux inactivity to pin two.
// RULE_12: Bit 1 routes double knock to pin one.
// RULE_13: Bit 1 routes double knock to pin two.
// RULE_14: Bit 0 routes single knock to pin one.
// RULE_15: Bit 0 routes single knock to pin two.
// RULE_16: Expiry sets status bit 4; read clears.
// RULE_17: Pin is OR of enabled sources.
// RULE_18: Map bit 5 reads zero, ignores writes.
module upper_irq_map (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic clk_en_i,
   input wire logic [irq_map_pkg::REG_AW-1:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [irq_map_pkg::REG_DW-1:0] reg_wdata_i,
   output logic [irq_map_pkg::REG_DW-1:0] reg_rdata_o,
   input wire logic fuse_error_i,
   input wire logic user_reg_error_i,
   input wire logic keepalive_expiry_i,
   input wire logic aux_activity_i,
   input wire logic aux_inactivity_i,
   input wire logic double_knock_i,
   input wire logic single_knock_i,
   input wire logic lower_pin_one_i,
   input wire logic lower_pin_two_i,
   output logic first_irq_pin_o,
   output logic second_irq_pin_o,
   output logic keepalive_status_o
);
   event_route_if route ();

   logic [7:0] pin_one_upper_event_map;
   logic [7:0] pin_two_upper_event_map;
   logic [7:0] second_status_register;
   logic [7:0] read_data;
   logic [7:0] next_read;
   logic hit_map_one;
   logic hit_map_two;
   logic hit_status;
   logic wr_one;
   logic wr_two;
   logic status_clear;
   logic next_keepalive;
   logic [7:0] masked_wdata;

   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
      addr_hit = (addr == target);
   endfunction

   assign hit_map_one = addr_hit(reg_addr_i, irq_map_pkg::PIN_ONE_MAP_ADDR);
   assign hit_map_two = addr_hit(reg_addr_i, irq_map_pkg::PIN_TWO_MAP_ADDR);
   assign hit_status = addr_hit(reg_addr_i, irq_map_pkg::STATUS_TWO_ADDR);
   assign wr_one = reg_wr_i & hit_map_one;
   assign wr_two = reg_wr_i & hit_map_two;
   // RULE_18: reserved bit dropped.
   assign masked_wdata = reg_wdata_i & irq_map_pkg::MAP_WRITABLE;

   // RULE_01: first map register.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_one_upper_event_map <= irq_map_pkg::MAP_RESET;
      end else if (clk_en_i && wr_one) begin
         pin_one_upper_event_map <= masked_wdata;
      end
   end

   // RULE_02: second map register.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_two_upper_event_map <= irq_map_pkg::MAP_RESET;
      end else if (clk_en_i && wr_two) begin
         pin_two_upper_event_map <= masked_wdata;
      end
   end

   // RULE_16: sticky status, set wins.
   assign status_clear = reg_rd_i & hit_status;
   assign next_keepalive = keepalive_expiry_i |
      (second_status_register[irq_map_pkg::STATUS_KEEPALIVE_BIT] & ~status_clear);

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         second_status_register <= irq_map_pkg::STATUS_RESET;
      end else if (clk_en_i) begin
         second_status_register[irq_map_pkg::STATUS_KEEPALIVE_BIT] <= next_keepalive;
      end
   end

   // Read data is captured so the status value seen is the one before its clear.
   assign next_read = !reg_rd_i ? irq_map_pkg::READ_IDLE :
                      hit_map_one ? pin_one_upper_event_map :
                      hit_map_two ? pin_two_upper_event_map :
                      hit_status ? second_status_register : irq_map_pkg::READ_IDLE;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         read_data <= irq_map_pkg::READ_IDLE;
      end else if (clk_en_i) begin
         read_data <= next_read;
      end
   end

   // RULE_03 RULE_04: fuse error slot.
   assign route.source_vec[irq_map_pkg::FUSE_ERROR_BIT] = fuse_error_i;
   // RULE_05 RULE_06: register error slot.
   assign route.source_vec[irq_map_pkg::USER_REG_ERROR_BIT] = user_reg_error_i;
   // RULE_18: reserved slot never drives.
   assign route.source_vec[irq_map_pkg::RESERVED_BIT] = 1'b0;
   // RULE_07: keep-alive status slot.
   assign route.source_vec[irq_map_pkg::KEEPALIVE_BIT] =
      second_status_register[irq_map_pkg::STATUS_KEEPALIVE_BIT];
   // RULE_08 RULE_09: aux activity slot.
   assign route.source_vec[irq_map_pkg::AUX_ACTIVITY_BIT] = aux_activity_i;
   // RULE_10 RULE_11: aux inactivity slot.
   assign route.source_vec[irq_map_pkg::AUX_INACTIVITY_BIT] = aux_inactivity_i;
   // RULE_12 RULE_13: double knock slot.
   assign route.source_vec[irq_map_pkg::DOUBLE_KNOCK_BIT] = double_knock_i;
   // RULE_14 RULE_15: single knock slot.
   assign route.source_vec[irq_map_pkg::SINGLE_KNOCK_BIT] = single_knock_i;
   assign route.map_one = pin_one_upper_event_map;
   assign route.map_two = pin_two_upper_event_map;
   assign route.lower_one = lower_pin_one_i;
   assign route.lower_two = lower_pin_two_i;

   event_pin_router u_router (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .clk_en_i(clk_en_i),
      .route(route)
   );

   assign first_irq_pin_o = route.pin_one;
   assign second_irq_pin_o = route.pin_two;
   assign keepalive_status_o = second_status_register[irq_map_pkg::STATUS_KEEPALIVE_BIT];
   assign reg_rdata_o = read_data;

   map_one_write_a: assert property ( // RULE_01
      @(posedge sys_clk_i) disable iff (rst_i)
      (clk_en_i && wr_one) |=> pin_one_upper_event_map == ($past(reg_wdata_i) & 8'hDF))
      else $error("pin one map did not take the write");

   map_two_write_a: assert property ( // RULE_02
      @(posedge sys_clk_i) disable iff (rst_i)
      (clk_en_i && wr_two) |=> pin_two_upper_event_map == ($past(reg_wdata_i) & 8'hDF))
      else $error("pin two map did not take the write");

   map_reserved_zero_a: assert property ( // RULE_18
      @(posedge sys_clk_i) disable iff (rst_i)
      (reg_rd_i && (hit_map_one || hit_map_two) && clk_en_i) |=> !reg_rdata_o[5])
      else $error("reserved map bit read back as one");

   fuse_pin_one_a: assert property ( // RULE_03
      @(posedge sys_clk_i) disable iff (rst_i)
      (clk_en_i && fuse_error_i && pin_one_upper_event_map[7]) |=> first_irq_pin_o)
      else $error("mapped fuse error did not raise pin one");

   fuse_pin_two_a: assert property ( // RULE_04
      @(posedge sys_clk_i) disable iff (rst_i)
      (clk_en_i && fuse_error_i && pin_two_upper_event_map[7]) |=> second_irq_pin_o)
      else $error("mapped fuse error did not raise pin two");

   knock_pin_one_a: assert property ( // RULE_14
      @(posedge sys_clk_i) disable iff (rst_i)
      (clk_en_i && single_knock_i && pin_one_upper_event_map[0]) |=> first_irq_pin_o)
      else $error("mapped single knock did not raise pin one");

   keepalive_pin_two_a: assert property ( // RULE_07
      @(posedge sys_clk_i) disable iff (rst_i)
      (clk_en_i && keepalive_status_o && pin_two_upper_event_map[4]) |=> second_irq_pin_o)
      else $error("keep-alive status did not raise pin two");

   pin_one_or_a: assert property ( // RULE_17
      @(posedge sys_clk_i) disable iff (rst_i)
      clk_en_i |=> first_irq_pin_o == ($past(|(route.source_vec & pin_one_upper_event_map))
                                        | $past(lower_pin_one_i)))
      else $error("pin one is not the OR of enabled sources");

   pin_two_quiet_a: assert property ( // RULE_17
      @(posedge sys_clk_i) disable iff (rst_i)
      (clk_en_i && pin_two_upper_event_map == 8'h00 && !lower_pin_two_i) |=> !second_irq_pin_o)
      else $error("pin two raised with nothing mapped");

   status_set_a: assert property ( // RULE_16
      @(posedge sys_clk_i) disable iff (rst_i)
      (clk_en_i && keepalive_expiry_i) |=> keepalive_status_o)
      else $error("expiry did not set the status bit");

   status_clear_a: assert property ( // RULE_16
      @(posedge sys_clk_i) disable iff (rst_i)
      (clk_en_i && status_clear && !keepalive_expiry_i) |=> !keepalive_status_o ##0
      reg_rdata_o[4] == $past(keepalive_status_o))
      else $error("status read did not clear or report the bit");

   frozen_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      !clk_en_i |=> $stable(pin_one_upper_event_map) && $stable(first_irq_pin_o))
      else $error("state moved with clock enable low");

   frozen_two_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      !clk_en_i |=> $stable(pin_two_upper_event_map) && $stable(second_irq_pin_o)
         && $stable(keepalive_status_o))
      else $error("pin two state moved with clock enable low");

   // Each mapped source must reach its pin one cycle after it is seen.
   user_err_pin_one_a: assert property ( // RULE_05
      @(posedge sys_clk_i) disable iff (rst_i)
      (clk_en_i && user_reg_error_i && pin_one_upper_event_map[6]) |=> first_irq_pin_o)
      else $error("mapped register error did not raise pin one");

   user_err_pin_two_a: assert property ( // RULE_06
      @(posedge sys_clk_i) disable iff (rst_i)
      (clk_en_i && user_reg_error_i && pin_two_upper_event_map[6]) |=> second_irq_pin_o)
      else $error("mapped register error did not raise pin two");

   keepalive_pin_one_a: assert property ( // RULE_07
      @(posedge sys_clk_i) disable iff (rst_i)
      (clk_en_i && keepalive_status_o && pin_one_upper_event_map[4]) |=> first_irq_pin_o)
      else $error("keep-alive status did not raise pin one");

   activity_pin_one_a: assert property ( // RULE_08
      @(posedge sys_clk_i) disable iff (rst_i)
      (clk_en_i && aux_activity_i && pin_one_upper_event_map[3]) |=> first_irq_pin_o)
      else $error("mapped aux activity did not raise pin one");

   activity_pin_two_a: assert property ( // RULE_09
      @(posedge sys_clk_i) disable iff (rst_i)
      (clk_en_i && aux_activity_i && pin_two_upper_event_map[3]) |=> second_irq_pin_o)
      else $error("mapped aux activity did not raise pin two");

   inactivity_pin_one_a: assert property ( // RULE_10
      @(posedge sys_clk_i) disable iff (rst_i)
      (clk_en_i && aux_inactivity_i && pin_one_upper_event_map[2]) |=> first_irq_pin_o)
      else $error("mapped aux inactivity did not raise pin one");

   inactivity_pin_two_a: assert property ( // RULE_11
      @(posedge sys_clk_i) disable iff (rst_i)
      (clk_en_i && aux_inactivity_i && pin_two_upper_event_map[2]) |=> second_irq_pin_o)
      else $error("mapped aux inactivity did not raise pin two");

   double_pin_one_a: assert property ( // RULE_12
      @(posedge sys_clk_i) disable iff (rst_i)
      (clk_en_i && double_knock_i && pin_one_upper_event_map[1]) |=> first_irq_pin_o)
      else $error("mapped double knock did not raise pin one");

   double_pin_two_a: assert property ( // RULE_13
      @(posedge sys_clk_i) disable iff (rst_i)
      (clk_en_i && double_knock_i && pin_two_upper_event_map[1]) |=> second_irq_pin_o)
      else $error("mapped double knock did not raise pin two");

   knock_pin_two_a: assert property ( // RULE_15
      @(posedge sys_clk_i) disable iff (rst_i)
      (clk_en_i && single_knock_i && pin_two_upper_event_map[0]) |=> second_irq_pin_o)
      else $error("mapped single knock did not raise pin two");

   pin_two_or_a: assert property ( // RULE_17
      @(posedge sys_clk_i) disable iff (rst_i)
      clk_en_i |=> second_irq_pin_o == ($past(|(route.source_vec & pin_two_upper_event_map))
                                         | $past(lower_pin_two_i)))
      else $error("pin two is not the OR of enabled sources");

   pin_one_quiet_a: assert property ( // RULE_17
      @(posedge sys_clk_i) disable iff (rst_i)
      (clk_en_i && pin_one_upper_event_map == 8'h00 && !lower_pin_one_i) |=> !first_irq_pin_o)
      else $error("pin one raised with nothing mapped");

   // Reset is checked at the first edge after release, when the flops show reset values.
   reset_values_a: assert property ( // RULE_01
      @(posedge sys_clk_i)
      $fell(rst_i) |-> (pin_one_upper_event_map == irq_map_pkg::MAP_RESET)
         && (pin_two_upper_event_map == irq_map_pkg::MAP_RESET) && !first_irq_pin_o)
      else $error("maps or pin not cleared by reset");

   read_idle_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      (clk_en_i && !reg_rd_i) |=> reg_rdata_o == irq_map_pkg::READ_IDLE)
      else $error("read data did not return to idle");

   cover_fuse_c: cover property (
      @(posedge sys_clk_i) disable iff (rst_i) fuse_error_i && pin_one_upper_event_map[7]
      ##1 first_irq_pin_o);
   cover_keepalive_c: cover property (
      @(posedge sys_clk_i) disable iff (rst_i) keepalive_expiry_i ##1 status_clear
      ##1 !keepalive_status_o);
   cover_both_pins_c: cover property (
      @(posedge sys_clk_i) disable iff (rst_i) first_irq_pin_o && second_irq_pin_o);

   cover_set_wins_c: cover property (
      @(posedge sys_clk_i) disable iff (rst_i) keepalive_expiry_i && status_clear
      ##1 keepalive_status_o);

   cover_keepalive_one_c: cover property (
      @(posedge sys_clk_i) disable iff (rst_i) keepalive_status_o && pin_one_upper_event_map[4]
      ##1 first_irq_pin_o);
endmodule // upper_irq_map

// file: bench/host_pin_watch.sv
// Host model that watches the two interrupt pins and counts their rising edges.
module host_pin_watch (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic pin_one_i,
   input wire logic pin_two_i,
   output logic [7:0] rise_one_o,
   output logic [7:0] rise_two_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_one;
   logic last_two;
   // The host only sees pin levels, so it counts edges instead of trusting pulse widths.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         last_one <= 1'b0;
         last_two <= 1'b0;
         rise_one_o <= 8'h00;
         rise_two_o <= 8'h00;
      end else begin
         last_one <= pin_one_i;
         last_two <= pin_two_i;
         rise_one_o <= rise_one_o + 8'(pin_one_i & ~last_one);
         rise_two_o <= rise_two_o + 8'(pin_two_i & ~last_two);
      end
   end
endmodule // host_pin_watch

// file: bench/tb.sv
// Self-checking bench for the upper interrupt pin mapping block.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic en = 1'b1;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic kpa = 1'b0;
   logic low1 = 1'b0;
   logic low2 = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] src = 8'h00;
   logic [7:0] rdata;
   logic [7:0] rise1;
   logic [7:0] rise2;
   logic p1;
   logic p2;
   logic kst;
   int errors = 0;
   int total_checks = 0;
   always #12.5 clk = ~clk;
   upper_irq_map upper_irq_map_i (.sys_clk_i(clk), .rst_i(rst), .clk_en_i(en),
      .reg_addr_i(addr), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .fuse_error_i(src[7]), .user_reg_error_i(src[6]),
      .keepalive_expiry_i(kpa), .aux_activity_i(src[3]), .aux_inactivity_i(src[2]),
      .double_knock_i(src[1]), .single_knock_i(src[0]), .lower_pin_one_i(low1),
      .lower_pin_two_i(low2), .first_irq_pin_o(p1), .second_irq_pin_o(p2),
      .keepalive_status_o(kst));
   host_pin_watch host_pin_watch_i (.sys_clk_i(clk), .rst_i(rst), .pin_one_i(p1),
      .pin_two_i(p2), .rise_one_o(rise1), .rise_two_o(rise2));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 chk(n, e, rdata);
   endtask
   // Bit 4 is left out of the source mask: it is fed by the sticky keep-alive status.
   task automatic route(input logic [7:0] m1, input logic [7:0] m2, input logic [7:0] s);
      wr(8'h3A, m1);
      wr(8'h3B, m2);
      @(posedge clk);
      src <= s;
      repeat (2) @(posedge clk);
      #1;
      chk("pin_one", 8'(|(s & m1 & 8'hCF) | low1), 8'(p1));
      chk("pin_two", 8'(|(s & m2 & 8'hCF) | low2), 8'(p2));
   endtask
   task automatic t_regs();
      rd(8'h3A, 8'h00, "map_one_reset");
      rd(8'h3B, 8'h00, "map_two_reset");
      wr(8'h3A, 8'hFF);
      rd(8'h3A, 8'hDF, "map_one_bit5");
      wr(8'h3B, 8'hFF);
      rd(8'h3B, 8'hDF, "map_two_bit5");
      wr(8'h3A, 8'h20);
      wr(8'h3C, 8'hFF);
      rd(8'h3A, 8'h00, "map_one_other");
      rd(8'h3C, 8'h00, "unmapped_read");
      @(posedge clk);
      en <= 1'b0;
      wr(8'h3B, 8'h41);
      en <= 1'b1;
      rd(8'h3B, 8'hDF, "frozen_write");
      $display("register test done");
   endtask
   task automatic t_route();
      logic [7:0] b;
      for (int i = 0; i < 8; i++) begin
         b = 8'h01 << i;
         if ((b & 8'hCF) != 8'h00) begin
            route(b, 8'hCF & ~b, b);
            route(8'hCF & ~b, b, b);
         end
      end
      route(8'h03, 8'h00, 8'h01);
      @(posedge clk);
      low1 <= 1'b1;
      route(8'h00, 8'h00, 8'hCF);
      @(posedge clk);
      low1 <= 1'b0;
      low2 <= 1'b1;
      route(8'h00, 8'h00, 8'hCF);
      @(posedge clk);
      low2 <= 1'b0;
      $display("routing test done");
   endtask
   task automatic t_keep();
      logic [7:0] r0;
      wr(8'h3A, 8'h00);
      wr(8'h3B, 8'h10);
      #1 r0 = rise2;
      @(posedge clk);
      kpa <= 1'b1;
      @(posedge clk);
      kpa <= 1'b0;
      @(posedge clk);
      #1;
      chk("keep_status", 8'h01, 8'(kst));
      chk("keep_pin_two", 8'h01, 8'(p2));
      chk("keep_pin_one", 8'h00, 8'(p1));
      rd(8'h0F, 8'h10, "status_read");
      @(posedge clk);
      #1;
      chk("keep_cleared", 8'h00, 8'(kst));
      chk("keep_pin_low", 8'h00, 8'(p2));
      chk("host_rises", r0 + 8'h01, rise2);
      rd(8'h0F, 8'h00, "status_again");
      wr(8'h3A, 8'h10);
      wr(8'h3B, 8'h00);
      #1 r0 = rise1;
      // An expiry in the same edge as the status read must leave the bit set.
      @(posedge clk);
      kpa <= 1'b1;
      addr <= 8'h0F;
      rd_s <= 1'b1;
      @(posedge clk);
      kpa <= 1'b0;
      rd_s <= 1'b0;
      @(posedge clk);
      #1;
      chk("set_wins", 8'h01, 8'(kst));
      chk("keep_pin_one_on", 8'h01, 8'(p1));
      chk("keep_pin_two_off", 8'h00, 8'(p2));
      rd(8'h0F, 8'h10, "status_after_race");
      chk("host_rises_one", r0 + 8'h01, rise1);
      $display("keep-alive test done");
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("[FAIL] watchdog expected finish seen hang");
      results();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_route();
      t_keep();
      results();
   end
endmodule // tb
